// file: design/ldm_display_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - glyph index register on low bits
// - index lines pick row of glyph
// - full control word, index ignored
// - bits 2-0 set brightness, 111 blank
// - flash enabled digits toggle at divided rate
// - blink enable blinks all digits
// - blink overrides flash
// - bit 6 starts test, bit 5 pass
// - rom checksum decides pass bit
// - checkerboard then inverse shown
// - self test lasts 262144 clocks
// - test end blanks, clears, index ones
// - flash select low picks flash bit
// - clear bit blanks chars, clears flash
// - device returns clear bit to zero
// - reset clears char and flash rams, word, counters
// - write taken on write strobe rise
// - char ram, bit 7 picks glyph
// - clear keeps other control bits
module ldm_display_ctrl
  import ldm_pkg::*;
#(
  parameter int BLINK_DIV_P = BLINK_DIV,
  parameter int TEST_LEN_P  = TEST_CYCLES
)(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  // host bus
  input  wire logic       chip_sel_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       attr_mem_select_n_i,
  input  wire logic       region_sel_hi_i,
  input  wire logic       region_sel_lo_i,
  input  wire logic [2:0] index_lines_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  // display state
  output logic      [7:0] digit_on_o,
  output logic      [2:0] brightness_o,
  output logic            pattern_on_o,
  output logic            pattern_inv_o,
  output logic            busy_o
);
  // counters must hold the half divide and the whole rom phase
  if (BLINK_DIV_P < 2 || TEST_LEN_P < 2 * ROM_STATES) begin : g_bad_param
    $error("ldm: bad timing parameter");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_CLEAR, ST_TEST} ldm_state_t;

  ldm_state_t state_ff;
  logic [7:0] ctrl_ff;
  logic [3:0] glyph_idx_ff;
  logic [7:0] char_ff [0:NUM_DIGITS-1];
  logic [7:0] flash_ff;
  logic [$clog2(TEST_LEN_P)-1:0] tcnt_ff;
  logic [$clog2(BLINK_DIV_P)-1:0] div_ff;
  logic       phase_ff;
  logic [15:0] sum_ff;
  logic       wr_n_d_ff;
  logic [7:0] data_ff;
  logic       oe_ff;
  logic [7:0] digit_ff;
  logic [2:0] bright_ff;
  logic       pat_ff;
  logic       pinv_ff;
  logic       busy_ff;
  ldm_mem_if  gmem ();

  logic       wr_rise;
  logic       clr_done;
  logic       test_done;
  logic [1:0] region;
  assign region = {region_sel_hi_i, region_sel_lo_i};
  assign wr_rise   = wr_n_i && !wr_n_d_ff && !chip_sel_n_i && state_ff == ST_IDLE;
  assign clr_done  = state_ff == ST_CLEAR && tcnt_ff == ($bits(tcnt_ff))'(CLEAR_CYCLES - 1);
  assign test_done = state_ff == ST_TEST && tcnt_ff == ($bits(tcnt_ff))'(TEST_LEN_P - 1);

  ldm_glyph_ram u_gram (
    .clk_sys_i (clk_sys_i),
    .bus       (gmem)
  );
  assign gmem.we    = wr_rise && attr_mem_select_n_i && region == REG_GLYPH_ROW;
  assign gmem.addr  = {glyph_idx_ff, index_lines_i};
  assign gmem.wdata = data_i[4:0];

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_n_d_ff <= 1'b1;
    end else begin
      wr_n_d_ff <= wr_n_i;
    end
  end

  // sequencer: reset cycle, clear, self test
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= ST_RESET;
      tcnt_ff  <= '0;
    end else begin
      unique case (state_ff)
        ST_RESET: begin
          tcnt_ff <= tcnt_ff + 1'b1;
          if (tcnt_ff == ($bits(tcnt_ff))'(RESET_CYCLES - 1)) begin
            state_ff <= ST_IDLE;
            tcnt_ff  <= '0;
          end
        end
        ST_IDLE: begin
          tcnt_ff <= '0;
          if (wr_rise && attr_mem_select_n_i && region == REG_CTRL) begin
            if (data_i[CW_TEST]) begin
              state_ff <= ST_TEST;
            end else if (data_i[CW_CLEAR]) begin
              state_ff <= ST_CLEAR;
            end
          end
        end
        ST_CLEAR: begin
          tcnt_ff <= tcnt_ff + 1'b1;
          if (clr_done) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_TEST: begin
          tcnt_ff <= tcnt_ff + 1'b1;
          if (test_done) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // control word
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_ff <= CTRL_RST;
    end else if (test_done) begin
      ctrl_ff <= CTRL_RST | ({7'h00, sum_ff == ROM_SUM_OK} << CW_PASS);
    end else if (clr_done) begin
      ctrl_ff[CW_CLEAR] <= 1'b0;
    end else if (wr_rise && attr_mem_select_n_i && region == REG_CTRL) begin
      // whole word, pass bit read only
      ctrl_ff <= {data_i[7:6], ctrl_ff[CW_PASS], data_i[4:0]};
    end
  end

  // glyph index register
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      glyph_idx_ff <= GLYPH_RST;
    end else if (test_done) begin
      glyph_idx_ff <= GLYPH_TEST;
    end else if (wr_rise && attr_mem_select_n_i && region == REG_GLYPH_IDX) begin
      glyph_idx_ff <= data_i[3:0];
    end
  end

  // character and flash ram, small enough for flops
  genvar g;
  generate
    for (g = 0; g < NUM_DIGITS; g++) begin : g_digit
      always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
          char_ff[g]  <= CHAR_BLANK;
          flash_ff[g] <= 1'b0;
        end else if (state_ff == ST_RESET || clr_done || test_done) begin
          char_ff[g]  <= CHAR_BLANK;
          flash_ff[g] <= 1'b0;
        end else if (wr_rise && index_lines_i == 3'(g)) begin
          // flash bit on data bit 0
          if (!attr_mem_select_n_i) begin
            flash_ff[g] <= data_i[0];
          end else if (region == REG_CHAR) begin
            char_ff[g] <= data_i[CHAR_UDC] ? {1'b1, 3'h0, data_i[3:0]} : {1'b0, data_i[6:0]};
          end
        end
      end
    end
  endgenerate

  // blink divider, zeroed by reset to align displays
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      div_ff   <= '0;
      phase_ff <= 1'b0;
    end else if (state_ff == ST_RESET) begin
      div_ff   <= '0;
      phase_ff <= 1'b0;
    end else if (div_ff == ($bits(div_ff))'(BLINK_DIV_P / 2 - 1)) begin
      // half period toggle, full period is the divide
      div_ff   <= '0;
      phase_ff <= !phase_ff;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // rom checksum model: sums the 128 rom states in the first test phase
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sum_ff <= '0;
    end else if (state_ff != ST_TEST) begin
      sum_ff <= '0;
    end else if (tcnt_ff < ($bits(tcnt_ff))'(ROM_STATES)) begin
      sum_ff <= sum_ff + 16'(tcnt_ff[6:0]);
    end
  end

  // read mux, registered; glyph row arrives two cycles after address
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      data_ff <= 8'h00;
      oe_ff   <= 1'b0;
    end else begin
      oe_ff <= !chip_sel_n_i && !rd_n_i;
      if (!attr_mem_select_n_i) begin
        data_ff <= {7'h00, flash_ff[index_lines_i]};
      end else begin
        unique case (region)
          REG_GLYPH_IDX: data_ff <= {4'h0, glyph_idx_ff};
          REG_GLYPH_ROW: data_ff <= {3'h0, gmem.rdata};
          REG_CTRL:      data_ff <= ctrl_ff;
          REG_CHAR:      data_ff <= char_ff[index_lines_i];
        endcase
      end
    end
  end

  // display attributes
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      digit_ff  <= 8'h00;
      bright_ff <= 3'h0;
      pat_ff    <= 1'b0;
      pinv_ff   <= 1'b0;
      busy_ff   <= 1'b1;
    end else begin
      busy_ff <= state_ff != ST_IDLE;
      // brightness code passed to column duty
      bright_ff <= ctrl_ff[CW_BRIGHT_LSB +: 3];
      // checkerboard after rom phase, inverse in second half
      pat_ff  <= state_ff == ST_TEST && tcnt_ff >= ($bits(tcnt_ff))'(ROM_STATES);
      pinv_ff <= state_ff == ST_TEST && tcnt_ff >= ($bits(tcnt_ff))'(TEST_LEN_P / 2);
      if (ctrl_ff[CW_BLINK]) begin
        digit_ff <= {8{phase_ff}};
      end else if (ctrl_ff[CW_FLASH]) begin
        digit_ff <= ~(flash_ff & {8{phase_ff}});
      end else begin
        digit_ff <= 8'hFF;
      end
    end
  end

  assign data_o        = data_ff;
  assign data_oe_o     = oe_ff;
  assign digit_on_o    = digit_ff;
  assign brightness_o  = bright_ff;
  assign pattern_on_o  = pat_ff;
  assign pattern_inv_o = pinv_ff;
  assign busy_o        = busy_ff;

  chk_clear_self_ends: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state_ff == ST_IDLE && $past(state_ff) == ST_CLEAR |-> !ctrl_ff[CW_CLEAR])
    else $error("clear bit not returned to zero");
  chk_clear_len: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(state_ff == ST_CLEAR) |-> (state_ff == ST_CLEAR) [*3] ##1 state_ff == ST_IDLE)
    else $error("clear does not last three cycles");
  chk_clear_fill: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr_done |=> flash_ff == 8'h00 && char_ff[0] == CHAR_BLANK)
    else $error("clear left ram dirty");
  chk_clear_keeps: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr_done |=> ctrl_ff[6:0] == $past(ctrl_ff[6:0]))
    else $error("clear changed control bits");
  chk_test_end: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    test_done |=> glyph_idx_ff == GLYPH_TEST && ctrl_ff[7:6] == 2'h0 && ctrl_ff[4:0] == 5'h00)
    else $error("test end state wrong");
  chk_pass_bit: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    test_done |=> ctrl_ff[CW_PASS] == $past(sum_ff == ROM_SUM_OK))
    else $error("pass bit does not match checksum");
  chk_blink_all: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ctrl_ff[CW_BLINK] |=> digit_ff == {8{$past(phase_ff)}})
    else $error("blink not applied to all digits");
  chk_bus_drive: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    data_oe_o |-> $past(!chip_sel_n_i && !rd_n_i))
    else $error("bus driven outside read");
  chk_reset_cycle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(state_ff == ST_RESET) |-> $past(tcnt_ff) == 2'h2)
    else $error("reset cycle length wrong");
  chk_glyph_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_rise && attr_mem_select_n_i && region == REG_GLYPH_IDX
      |=> glyph_idx_ff == $past(data_i[3:0]))
    else $error("glyph index not stored");
  chk_flash_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_rise && !attr_mem_select_n_i |=> flash_ff[$past(index_lines_i)] == $past(data_i[0]))
    else $error("flash bit not stored");
  chk_ctrl_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_rise && attr_mem_select_n_i && region == REG_CTRL
      |=> ctrl_ff[7:6] == $past(data_i[7:6]) && ctrl_ff[4:0] == $past(data_i[4:0]))
    else $error("control word not stored");
  chk_pass_ro: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_rise && attr_mem_select_n_i && region == REG_CTRL |=> $stable(ctrl_ff[CW_PASS]))
    else $error("pass bit written by host");
  chk_test_start: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_rise && attr_mem_select_n_i && region == REG_CTRL && data_i[CW_TEST]
      |=> state_ff == ST_TEST)
    else $error("self test not started");
  chk_pattern_order: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    pinv_ff |-> pat_ff)
    else $error("inverse pattern before checkerboard");

  cov_clear: cover property (@(posedge clk_sys_i) disable iff (reset_i) clr_done);
  cov_blink: cover property (@(posedge clk_sys_i) disable iff (reset_i) ctrl_ff[CW_BLINK]);
  cov_test: cover property (@(posedge clk_sys_i) disable iff (reset_i) test_done);
  cov_flash: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    ctrl_ff[CW_FLASH] && !ctrl_ff[CW_BLINK] && flash_ff != 8'h00);
endmodule : ldm_display_ctrl

// file: design/ldm_pkg.sv
package ldm_pkg;
  // region decode {region_sel_hi, region_sel_lo}
  localparam logic [1:0] REG_GLYPH_IDX  = 2'h0;
  localparam logic [1:0] REG_GLYPH_ROW  = 2'h1;
  localparam logic [1:0] REG_CTRL       = 2'h2;
  localparam logic [1:0] REG_CHAR       = 2'h3;
  // control word fields
  localparam int CW_BRIGHT_LSB = 0;
  localparam int CW_FLASH      = 3;
  localparam int CW_BLINK      = 4;
  localparam int CW_PASS       = 5;
  localparam int CW_TEST       = 6;
  localparam int CW_CLEAR      = 7;
  localparam int CHAR_UDC      = 7;
  // reset and fill values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] CHAR_BLANK = 8'h20;
  localparam logic [3:0] GLYPH_RST  = 4'h0;
  localparam logic [3:0] GLYPH_TEST = 4'hF;
  localparam logic [4:0] ROW_RST    = 5'h00;
  // timing in display clock periods, checksum and sizes
  localparam int BLINK_DIV    = 28672;
  localparam int TEST_CYCLES  = 262144;
  localparam int CLEAR_CYCLES = 3;
  localparam int RESET_CYCLES = 3;
  localparam int ROM_STATES   = 128;
  localparam logic [15:0] ROM_SUM_OK = 16'h1FC0;
  localparam int NUM_DIGITS   = 8;
  localparam int NUM_ROWS     = 7;
  localparam int NUM_GLYPHS   = 16;
endpackage : ldm_pkg

// file: design/ldm_mem_if.sv
`timescale 1ns/1ps
interface ldm_mem_if;
  logic       we;
  logic [6:0] addr;
  logic [4:0] wdata;
  logic [4:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : ldm_mem_if

// file: design/ldm_glyph_ram.sv
`timescale 1ns/1ps
module ldm_glyph_ram
  import ldm_pkg::*;
(
  input wire logic clk_sys_i,
  ldm_mem_if.mem   bus
);
  // glyph rows, 16 glyphs x 8 row slots (slot 7 unused)
  logic [4:0] mem_ff [0:127];
  logic [4:0] rdata_ff;

  always_ff @(posedge clk_sys_i) begin
    if (bus.we) begin
      mem_ff[bus.addr] <= bus.wdata;
    end
  end

  // registered read for block-ram mapping
  always_ff @(posedge clk_sys_i) begin
    rdata_ff <= mem_ff[bus.addr];
  end

  assign bus.rdata = rdata_ff;
endmodule : ldm_glyph_ram

// file: bench/ldm_host_model.sv
`timescale 1ns/1ps
module ldm_host_model (
  // clock and status
  input  wire logic       clk_sys_i,
  input  wire logic       busy_i,
  input  wire logic [7:0] data_i,
  input  wire logic       data_oe_i,
  // host bus
  output logic            chip_sel_n_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic [2:0]      sel_o,
  output logic [2:0]      index_o,
  output logic [7:0]      dq_o
);
  initial begin
    chip_sel_n_o = 1'b1;
    wr_n_o       = 1'b1;
    rd_n_o       = 1'b1;
    sel_o        = 3'h0;
    index_o      = 3'h0;
    dq_o         = 8'h00;
  end
  task automatic wait_idle();
    // unbounded on purpose: the bench watchdog ends a stuck busy
    while (busy_i !== 1'b0) begin
      @(negedge clk_sys_i);
    end
  endtask : wait_idle
  task automatic wr(input logic [2:0] sel, input logic [2:0] idx, input logic [7:0] d);
    wait_idle();
    @(negedge clk_sys_i);
    sel_o        = sel;
    index_o      = idx;
    dq_o         = d;
    chip_sel_n_o = 1'b0;
    wr_n_o       = 1'b0;
    @(negedge clk_sys_i);
    wr_n_o       = 1'b1;
    @(negedge clk_sys_i);
    chip_sel_n_o = 1'b1;
    // released bus shows inverse so stale data cannot pass
    dq_o         = ~d;
    repeat (2) @(negedge clk_sys_i);
  endtask : wr
  task automatic rd(input logic [2:0] sel, input logic [2:0] idx,
                    output logic [7:0] d, output logic oe);
    wait_idle();
    @(negedge clk_sys_i);
    sel_o        = sel;
    index_o      = idx;
    chip_sel_n_o = 1'b0;
    rd_n_o       = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    d            = data_i;
    oe           = data_oe_i;
    chip_sel_n_o = 1'b1;
    rd_n_o       = 1'b1;
    repeat (2) @(negedge clk_sys_i);
  endtask : rd
endmodule : ldm_host_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ldm_pkg::*;
  localparam int BLK = 32;
  localparam int TST = 512;
  localparam logic [2:0] S_IDX = 3'h4, S_ROW = 3'h5, S_CW = 3'h6, S_CHR = 3'h7, S_FL = 3'h0;
  logic       clk_sys_i = 1'b0;
  logic       reset_i   = 1'b1;
  logic       cs_n, wr_n, rd_n, oe, busy, pat, inv;
  logic [2:0] sel, idx, bright;
  logic [7:0] dq, dout, digs;
  int         n_mismatch = 0;
  int         num_checks = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  ldm_display_ctrl #(.BLINK_DIV_P(BLK), .TEST_LEN_P(TST)) ldm_display_ctrl_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .chip_sel_n_i(cs_n), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .attr_mem_select_n_i(sel[2]), .region_sel_hi_i(sel[1]),
    .region_sel_lo_i(sel[0]), .index_lines_i(idx), .data_i(dq), .data_o(dout),
    .data_oe_o(oe), .digit_on_o(digs), .brightness_o(bright), .pattern_on_o(pat),
    .pattern_inv_o(inv), .busy_o(busy));
  ldm_host_model ldm_host_model_i (
    .clk_sys_i(clk_sys_i), .busy_i(busy), .data_i(dout), .data_oe_i(oe),
    .chip_sel_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .sel_o(sel), .index_o(idx),
    .dq_o(dq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rdchk(input logic [2:0] s, input logic [2:0] i, input logic [7:0] e);
    logic [7:0] d;
    logic       o;
    ldm_host_model_i.rd(s, i, d, o);
    check(d, e);
    check({6'h00, o, oe}, 8'h02);
  endtask : rdchk
  task automatic wr(input logic [2:0] s, input logic [2:0] i, input logic [7:0] d);
    ldm_host_model_i.wr(s, i, d);
  endtask : wr
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic t_reset();
    rdchk(S_CW, 3'h0, CTRL_RST);
    rdchk(S_FL, 3'h5, 8'h00);
    rdchk(S_CHR, 3'h2, CHAR_BLANK);
  endtask : t_reset
  task automatic t_regs();
    wr(S_IDX, 3'h6, 8'hA5);
    rdchk(S_IDX, 3'h1, 8'h05);
    for (int r = 0; r < 7; r++) wr(S_ROW, 3'(r), 8'hE0 | 8'(r * 3));
    for (int r = 0; r < 7; r++) rdchk(S_ROW, 3'(r), 8'(r * 3));
    wr(S_CW, 3'h5, 8'h27);
    rdchk(S_CW, 3'h2, 8'h07);
    check({5'h0, bright}, 8'h07);
    wr(S_CW, 3'h0, 8'h03);
    check({5'h0, bright}, 8'h03);
    wr(S_FL, 3'h3, 8'hFF);
    rdchk(S_FL, 3'h3, 8'h01);
    rdchk(S_FL, 3'h4, 8'h00);
    wr(S_CHR, 3'h1, 8'h85);
    rdchk(S_CHR, 3'h1, 8'h85);
  endtask : t_regs
  task automatic watch(output int t0, output int t3, output int diff);
    logic [7:0] p;
    t0 = 0;
    t3 = 0;
    diff = 0;
    p = digs;
    repeat (4 * BLK) begin
      @(negedge clk_sys_i);
      if (digs[0] !== p[0]) t0++;
      if (digs[3] !== p[3]) t3++;
      if (digs[0] !== digs[3]) diff++;
      p = digs;
    end
  endtask : watch
  task automatic t_flash();
    int a, b, c;
    for (int d = 0; d < 8; d++) wr(S_CHR, 3'(d), 8'h41);
    wr(S_CW, 3'h0, 8'h08);
    watch(a, b, c);
    check(8'(a), 8'h00);
    check(8'(b), 8'(4 * BLK / (BLK / 2)));
    wr(S_CW, 3'h0, 8'h18);
    watch(a, b, c);
    check(8'(a), 8'(4 * BLK / (BLK / 2)));
    check(8'(c), 8'h00);
    wr(S_CW, 3'h0, 8'h00);
    watch(a, b, c);
    check(8'(a + b), 8'h00);
  endtask : t_flash
  task automatic t_clear();
    int n;
    n = 0;
    wr(S_CW, 3'h0, 8'h8B);
    while (busy === 1'b1 && n < 50) begin
      @(negedge clk_sys_i);
      n++;
    end
    check(8'(n <= CLEAR_CYCLES + 2), 8'h01);
    rdchk(S_CW, 3'h0, 8'h0B);
    rdchk(S_CHR, 3'h1, CHAR_BLANK);
    rdchk(S_FL, 3'h3, 8'h00);
  endtask : t_clear
  task automatic t_test();
    int  n;
    logic sp, si;
    n = 0;
    sp = 1'b0;
    si = 1'b0;
    wr(S_FL, 3'h2, 8'h01);
    ldm_host_model_i.wr(S_CW, 3'h0, 8'h4A);
    while (busy === 1'b1 && n < 2000) begin
      @(negedge clk_sys_i);
      n++;
      sp = sp | (pat === 1'b1);
      si = si | (inv === 1'b1);
    end
    check(8'(n > TST - 10 && n <= TST + 8), 8'h01);
    check({6'h0, sp, si}, 8'h03);
    rdchk(S_CW, 3'h0, 8'h20);
    rdchk(S_IDX, 3'h0, {4'h0, GLYPH_TEST});
    rdchk(S_FL, 3'h2, 8'h00);
    rdchk(S_CHR, 3'h0, CHAR_BLANK);
  endtask : t_test
  task automatic t_rst_mid();
    wr(S_CHR, 3'h2, 8'h41);
    wr(S_FL, 3'h5, 8'h01);
    wr(S_CW, 3'h0, 8'h1B);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_reset();
    check(digs, 8'hFF);
    check({5'h0, bright}, 8'h00);
  endtask : t_rst_mid
  initial begin
    repeat (2) @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_reset();
    t_regs();
    t_flash();
    t_clear();
    t_test();
    t_rst_mid();
    final_report();
  end
  // whole run needs about 1200 cycles
  initial begin
    #(20000 * 50);
    n_mismatch++;
    final_report();
  end
endmodule : testbench
